/* ddrcd_ctl.sv */
// controller end: makes the link clock, encodes requests onto the command pins
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_defs.svh"

module ddrcd_ctl (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // link to the device
  ddrcd_if.ctl                          link,
  // request from the user
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire ddrcd_pkg::ddrcd_cmd_t    req_cmd,
  input  wire logic [`DDRCD_BA_W-1:0]   req_bank,
  input  wire logic [`DDRCD_ADDR_W-1:0] req_addr,
  input  wire logic                     req_auto_close,
  // low power requests, levels
  input  wire logic                     pd_req,
  input  wire logic                     sr_req,
  // status
  output logic                          req_error,
  output logic [`DDRCD_BANKS-1:0]       bank_open,
  output logic                          link_cke
);

  ddrcd_pkg::ddrcd_ctl_state_t st;
  ddrcd_pkg::ddrcd_ctl_state_t next_st;
  logic                        launch;
  logic                        all_idle;
  logic                        low_req;

  // pins change only while the link clock falls, so the device sees them settled at the rise
  assign launch   = st.ck;
  assign all_idle = (st.bank_open == `DDRCD_BANK_IDLE);
  assign low_req  = pd_req | sr_req;
  // requests stall while low power is pending with every bank idle
  assign req_ready = launch & st.cke & ~(low_req & all_idle);

  // pins and status straight from the state flops
  assign link.diff_clock_true = st.ck;
  assign link.diff_clock_comp = ~st.ck;
  assign link.cke             = st.cke;
  assign link.cs_n            = st.cs_n;
  assign link.ras_n           = st.ras_n;
  assign link.cas_n           = st.cas_n;
  assign link.we_n            = st.we_n;
  assign link.bank_select     = st.ba;
  assign link.address_bus     = st.addr;
  assign req_error            = st.req_error;
  assign bank_open            = st.bank_open;
  assign link_cke             = st.cke;

  // next state: divider, power control, command encoding
  always_comb begin
    next_st           = st;
    next_st.ck        = ~st.ck;
    next_st.req_error = 1'b0;
    if (launch) begin
      // deselect by default and leave the strobes where they stand: fewer pin toggles,
      // so the decoder must mask whatever the held strobes spell
      next_st.cs_n = 1'b1;
      if (!st.cke) begin
        if (!low_req) begin
          next_st.cke   = 1'b1;                            // exit with a selected nop
          next_st.cs_n  = 1'b0;
          next_st.ras_n = 1'b1;
          next_st.cas_n = 1'b1;
          next_st.we_n  = 1'b1;
        end
      end else if (low_req && all_idle) begin
        next_st.cke   = 1'b0;
        next_st.cs_n  = 1'b0;
        next_st.ras_n = ~sr_req;                           // refresh with cke low enters self refresh
        next_st.cas_n = ~sr_req;
        next_st.we_n  = 1'b1;
      end else if (req_valid) begin
        next_st.ba = req_bank;
        unique case (req_cmd)
          ddrcd_pkg::cmd_open: begin
            next_st.cs_n               = 1'b0;
            next_st.ras_n              = 1'b0;
            next_st.cas_n              = 1'b1;
            next_st.we_n               = 1'b1;
            next_st.addr               = req_addr;         // full row address
            next_st.bank_open[req_bank] = 1'b1;
          end
          ddrcd_pkg::cmd_close: begin
            next_st.cs_n               = 1'b0;
            next_st.ras_n              = 1'b0;
            next_st.cas_n              = 1'b1;
            next_st.we_n               = 1'b0;
            next_st.bank_open[req_bank] = 1'b0;
          end
          ddrcd_pkg::cmd_read, ddrcd_pkg::cmd_write: begin
            if (st.bank_open[req_bank]) begin              // only into an open row
              next_st.cs_n  = 1'b0;
              next_st.ras_n = 1'b1;
              next_st.cas_n = 1'b0;
              next_st.we_n  = (req_cmd == ddrcd_pkg::cmd_read);
              next_st.addr  = {{(`DDRCD_ADDR_W-`DDRCD_COL_W){1'b0}}, req_addr[`DDRCD_COL_MSB:0]};
              next_st.addr[`DDRCD_AUTO_BIT] = req_auto_close;
              if (req_auto_close) next_st.bank_open[req_bank] = 1'b0;
            end else begin
              next_st.req_error = 1'b1;                    // dropped, link stays deselected
            end
          end
          ddrcd_pkg::cmd_refresh: begin
            next_st.cs_n  = 1'b0;
            next_st.ras_n = 1'b0;
            next_st.cas_n = 1'b0;
            next_st.we_n  = 1'b1;
          end
          default: ;                                       // nop and others leave the link deselected
        endcase
      end
    end
  end

  // state register, deselected and idle after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st           <= '0;
      st.cs_n      <= 1'b1;
      st.ras_n     <= 1'b1;
      st.cas_n     <= 1'b1;
      st.we_n      <= 1'b1;
      st.cke       <= 1'b1;
      st.bank_open <= `DDRCD_BANK_IDLE;
    end else begin
      st <= next_st;
    end
  end

endmodule : ddrcd_ctl

`default_nettype wire

/* ddrcd_defs.svh */
// constants of the ddr command front end: widths, field positions, reset values
`ifndef DDRCD_DEFS_SVH
`define DDRCD_DEFS_SVH

// bus widths
`define DDRCD_ADDR_W     13
`define DDRCD_BA_W       2
`define DDRCD_COL_W      10
`define DDRCD_BANKS      4

// field positions on the address bus
`define DDRCD_COL_MSB    9
`define DDRCD_AUTO_BIT   10

// reset values
`define DDRCD_BANK_IDLE  4'h0
`define DDRCD_CKE_RST    1'h0

`endif

/* ddrcd_dev.sv */
// device end: samples the command pins at link clock rises and decodes them
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_defs.svh"

// Overview of operation
// - cke low suspends clock, freezes outputs except xfer_tick
// - cke low with banks idle: power-down, or self refresh with a refresh command
// - bank select picks the single target bank
// - activate captures full thirteen-bit row address
// - column from low ten bits, bit ten auto-close
// - chip select high masks every command
// - ras, cas, we decoded together each rise
// - ras low, cas we high opens row
// - ras we low, cas high closes row
// - ras high, cas low reads or writes
// - sample where true rises, complement falls
// - data ticks at both crossing directions
module ddrcd_dev (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // link from the controller
  ddrcd_if.dev                          link,
  // decoded command, one-cycle strobe
  output logic                          cmd_valid,
  output ddrcd_pkg::ddrcd_cmd_t         cmd,
  output logic [`DDRCD_BA_W-1:0]        cmd_bank,
  output logic [`DDRCD_ADDR_W-1:0]      row_addr,
  output logic [`DDRCD_COL_W-1:0]       col_addr,
  output logic                          auto_close_flag,
  // device state
  output logic [`DDRCD_BANKS-1:0]       bank_active,
  output ddrcd_pkg::ddrcd_pwr_t         pwr_state,
  output logic                          clk_suspended,
  // data timing
  output logic                          xfer_tick
);

  ddrcd_pkg::ddrcd_dev_state_t st;
  ddrcd_pkg::ddrcd_dev_state_t next_st;
  ddrcd_pkg::ddrcd_pins_t      pins;
  logic                        rise;
  logic                        fall;
  logic                        all_idle;
  ddrcd_pkg::ddrcd_cmd_t       dec;

  // gather the pins into one word for the synchroniser
  assign pins.ck_t  = link.diff_clock_true;
  assign pins.ck_c  = link.diff_clock_comp;
  assign pins.cke   = link.cke;
  assign pins.cs_n  = link.cs_n;
  assign pins.ras_n = link.ras_n;
  assign pins.cas_n = link.cas_n;
  assign pins.we_n  = link.we_n;
  assign pins.ba    = link.bank_select;
  assign pins.addr  = link.address_bus;

  // crossings seen after the second stage; first stage feeds nothing else
  assign rise = st.s2.ck_t & ~st.s3.ck_t & ~st.s2.ck_c & st.s3.ck_c;
  assign fall = ~st.s2.ck_t & st.s3.ck_t & st.s2.ck_c & ~st.s3.ck_c;

  assign all_idle = (st.bank_active == `DDRCD_BANK_IDLE);

  // command decode from the synchronised pins
  always_comb begin
    dec = ddrcd_pkg::cmd_nop;
    if (!st.s2.cs_n) begin
      unique case ({st.s2.ras_n, st.s2.cas_n, st.s2.we_n})
        3'h3: dec = ddrcd_pkg::cmd_open;
        3'h2: dec = ddrcd_pkg::cmd_close;
        3'h5: dec = ddrcd_pkg::cmd_read;
        3'h4: dec = ddrcd_pkg::cmd_write;
        3'h1: dec = ddrcd_pkg::cmd_refresh;
        3'h7: dec = ddrcd_pkg::cmd_nop;
        3'h0: dec = ddrcd_pkg::cmd_other;
        3'h6: dec = ddrcd_pkg::cmd_other;
      endcase
    end
  end

  // next state: sampling, power control, bank tracking
  always_comb begin
    next_st           = st;
    next_st.s1        = pins;
    next_st.s2        = st.s1;
    next_st.s3        = st.s2;
    next_st.cmd_valid = 1'b0;
    // data moves on both crossings, so the tick fires on each
    next_st.xfer_tick = rise | fall;
    if (rise) begin
      next_st.cke_q = st.s2.cke;
      if (!st.cke_q) begin
        // clock suspended: command outputs and addresses held, only cke is watched; xfer_tick still fires
        if (st.s2.cke) begin
          next_st.pwr = ddrcd_pkg::pwr_awake;
        end
      end else if (!st.s2.cke && all_idle) begin
        // entry command is consumed by the mode change, not reported
        if (dec == ddrcd_pkg::cmd_refresh) begin
          next_st.pwr = ddrcd_pkg::pwr_self;
        end else begin
          next_st.pwr = ddrcd_pkg::pwr_down;
        end
      end else if (dec != ddrcd_pkg::cmd_nop) begin
        next_st.cmd_valid = 1'b1;
        next_st.cmd       = dec;
        next_st.cmd_bank  = st.s2.ba;
        unique case (dec)
          ddrcd_pkg::cmd_open: begin
            next_st.row_addr              = st.s2.addr;
            next_st.bank_active[st.s2.ba] = 1'b1;
          end
          ddrcd_pkg::cmd_close: begin
            // precharge finishes at once; no row timing is modelled here
            next_st.bank_active[st.s2.ba] = 1'b0;
          end
          ddrcd_pkg::cmd_read, ddrcd_pkg::cmd_write: begin
            next_st.col_addr   = st.s2.addr[`DDRCD_COL_MSB:0];
            next_st.auto_close = st.s2.addr[`DDRCD_AUTO_BIT];
            // burst length is not tracked, so the close is taken as immediate
            if (st.s2.addr[`DDRCD_AUTO_BIT]) begin
              next_st.bank_active[st.s2.ba] = 1'b0;
            end
          end
          default: ;                                         // refresh and others touch no bank
        endcase
      end
    end
  end

  // state register; no reset pin on the real part, srst stands in for power-up
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st             <= '0;
      st.cke_q       <= `DDRCD_CKE_RST;
      st.pwr         <= ddrcd_pkg::pwr_awake;
      st.bank_active <= `DDRCD_BANK_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign cmd_valid       = st.cmd_valid;
  assign cmd             = st.cmd;
  assign cmd_bank        = st.cmd_bank;
  assign row_addr        = st.row_addr;
  assign col_addr        = st.col_addr;
  assign auto_close_flag = st.auto_close;
  assign bank_active     = st.bank_active;
  assign pwr_state       = st.pwr;
  assign clk_suspended   = ~st.cke_q;
  assign xfer_tick       = st.xfer_tick;

endmodule : ddrcd_dev

`default_nettype wire

/* ddrcd_if.sv */
// link between controller and device: differential clock, command and address pins
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_defs.svh"

interface ddrcd_if;
  logic                     diff_clock_true;
  logic                     diff_clock_comp;
  logic                     cke;
  logic                     cs_n;
  logic                     ras_n;
  logic                     cas_n;
  logic                     we_n;
  logic [`DDRCD_BA_W-1:0]   bank_select;
  logic [`DDRCD_ADDR_W-1:0] address_bus;

  // controller drives every pin
  modport ctl (
    output diff_clock_true, diff_clock_comp, cke, cs_n, ras_n, cas_n, we_n, bank_select, address_bus
  );

  // device only listens
  modport dev (
    input diff_clock_true, diff_clock_comp, cke, cs_n, ras_n, cas_n, we_n, bank_select, address_bus
  );
endinterface : ddrcd_if

`default_nettype wire

/* ddrcd_pkg.sv */
// shared types of the ddr command front end
`default_nettype none
`include "ddrcd_defs.svh"

package ddrcd_pkg;

  // decoded command codes
  typedef enum logic [2:0] {
    cmd_nop     = 3'h0,
    cmd_open    = 3'h1,
    cmd_close   = 3'h2,
    cmd_read    = 3'h3,
    cmd_write   = 3'h4,
    cmd_refresh = 3'h5,
    cmd_other   = 3'h6
  } ddrcd_cmd_t;

  // device power states
  typedef enum logic [1:0] {
    pwr_awake = 2'h0,
    pwr_down  = 2'h1,
    pwr_self  = 2'h2
  } ddrcd_pwr_t;

  // clock, command and address pins as one word
  typedef struct packed {
    logic                     ck_t;
    logic                     ck_c;
    logic                     cke;
    logic                     cs_n;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic [`DDRCD_BA_W-1:0]   ba;
    logic [`DDRCD_ADDR_W-1:0] addr;
  } ddrcd_pins_t;

  // device end state
  typedef struct packed {
    ddrcd_pins_t              s1;
    ddrcd_pins_t              s2;
    ddrcd_pins_t              s3;
    logic                     cke_q;
    ddrcd_pwr_t               pwr;
    logic [`DDRCD_BANKS-1:0]  bank_active;
    logic                     cmd_valid;
    ddrcd_cmd_t               cmd;
    logic [`DDRCD_BA_W-1:0]   cmd_bank;
    logic [`DDRCD_ADDR_W-1:0] row_addr;
    logic [`DDRCD_COL_W-1:0]  col_addr;
    logic                     auto_close;
    logic                     xfer_tick;
  } ddrcd_dev_state_t;

  // controller end state
  typedef struct packed {
    logic                     ck;
    logic                     cke;
    logic                     cs_n;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic [`DDRCD_BA_W-1:0]   ba;
    logic [`DDRCD_ADDR_W-1:0] addr;
    logic [`DDRCD_BANKS-1:0]  bank_open;
    logic                     req_error;
  } ddrcd_ctl_state_t;

endpackage : ddrcd_pkg

`default_nettype wire

/* ddrcd_properties.sv */
// wire-level checks on the link between controller and device ends
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_defs.svh"
module ddrcd_props_chk (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     srst,
  // link pins
  input wire logic                     diff_clock_true,
  input wire logic                     diff_clock_comp,
  input wire logic                     cke,
  input wire logic                     cs_n,
  input wire logic                     ras_n,
  input wire logic                     cas_n,
  input wire logic                     we_n,
  input wire logic [`DDRCD_BA_W-1:0]   bank_select,
  input wire logic [`DDRCD_ADDR_W-1:0] address_bus
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic                    ck_q;
  logic                    rise;
  logic [`DDRCD_BANKS-1:0] open_bits;
  assign rise = diff_clock_true & ~ck_q;
  // open rows tracked from the wire alone, so neither end is trusted
  always_ff @(posedge ref_clk) begin
    ck_q <= diff_clock_true;
    if (srst)
      open_bits <= `DDRCD_BANK_IDLE;
    else if (rise && cke && !cs_n && !ras_n && cas_n)
      open_bits[bank_select] <= we_n;
    else if (rise && cke && !cs_n && ras_n && !cas_n && address_bus[`DDRCD_AUTO_BIT])
      open_bits[bank_select] <= 1'h0;
  end
  chk_comp_inverse: assert property (diff_clock_comp == !diff_clock_true)
    else $error("link clock halves not inverse");
  chk_clock_toggles: assert property (!$past(srst) |-> diff_clock_true != $past(diff_clock_true))
    else $error("link clock missed a crossing");
  chk_pins_stand: assert property (rise |-> $stable({cke, cs_n, ras_n, cas_n, we_n, bank_select, address_bus}))
    else $error("command pins moved at a rise");
  chk_col_open_bank: assert property (rise && cke && !cs_n && ras_n && !cas_n |-> open_bits[bank_select])
    else $error("column access to a closed bank");
  chk_sleep_idle: assert property ($fell(cke) |-> open_bits == 4'h0)
    else $error("clock enable dropped with a bank open");
  chk_entry_command: assert property ($fell(cke) |-> we_n && (ras_n == cas_n))
    else $error("low power entry with a bad command");
  chk_exit_nop: assert property ($rose(cke) |-> ras_n && cas_n && we_n)
    else $error("low power exit without a nop");
  chk_idle_reset: assert property ($fell(srst) |-> cs_n && ras_n && cas_n && we_n && cke && !diff_clock_true)
    else $error("link not idle after reset");
endmodule : ddrcd_props_chk
`default_nettype wire

/* tb_ddr_sdram_command_decode.sv */
// self-checking bench: controller and device ends joined by the link
`timescale 1ns/100ps
`default_nettype none
`include "ddrcd_defs.svh"
module tb_ddr_sdram_command_decode;
  logic                     ref_clk;
  logic                     srst;
  logic                     req_valid;
  logic                     req_ready;
  ddrcd_pkg::ddrcd_cmd_t    req_cmd;
  logic [`DDRCD_BA_W-1:0]   req_bank;
  logic [`DDRCD_ADDR_W-1:0] req_addr;
  logic                     req_auto_close;
  logic                     pd_req;
  logic                     sr_req;
  logic                     req_error;
  logic [`DDRCD_BANKS-1:0]  bank_open;
  logic                     link_cke;
  logic                     cmd_valid;
  ddrcd_pkg::ddrcd_cmd_t    cmd;
  logic [`DDRCD_BA_W-1:0]   cmd_bank;
  logic [`DDRCD_ADDR_W-1:0] row_addr;
  logic [`DDRCD_COL_W-1:0]  col_addr;
  logic                     auto_close_flag;
  logic [`DDRCD_BANKS-1:0]  bank_active;
  ddrcd_pkg::ddrcd_pwr_t    pwr_state;
  logic                     clk_suspended;
  logic                     xfer_tick;
  int                       bad_count;
  int                       checked;
  int                       n;

  ddrcd_if link_if ();
  ddrcd_ctl ddrcd_ctl_i (.ref_clk(ref_clk), .srst(srst), .link(link_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_auto_close(req_auto_close), .pd_req(pd_req), .sr_req(sr_req), .req_error(req_error),
    .bank_open(bank_open), .link_cke(link_cke));
  ddrcd_dev ddrcd_dev_i (.ref_clk(ref_clk), .srst(srst), .link(link_if), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr),
    .auto_close_flag(auto_close_flag), .bank_active(bank_active), .pwr_state(pwr_state),
    .clk_suspended(clk_suspended), .xfer_tick(xfer_tick));
  ddrcd_props_chk ddrcd_props_chk_i (.ref_clk(ref_clk), .srst(srst),
    .diff_clock_true(link_if.diff_clock_true), .diff_clock_comp(link_if.diff_clock_comp),
    .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
    .we_n(link_if.we_n), .bank_select(link_if.bank_select), .address_bus(link_if.address_bus));

  // 50 MHz reference
  always #10 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // request handed over only at an edge where ready was high
  task automatic send(input ddrcd_pkg::ddrcd_cmd_t c, input logic [1:0] b, input logic [12:0] a, input logic ac);
    int i;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_auto_close <= ac;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (req_ready === 1'h1) break;
    end
    req_valid <= 1'h0;
    if (i == 8) begin
      check("req_ready timeout", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask : send

  // issue one request, then watch the device end for its decode
  task automatic do_cmd(input ddrcd_pkg::ddrcd_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                        input logic ac, input logic ok, input logic er);
    int   i;
    logic err;
    err = 1'h0;
    send(c, b, a, ac);
    // the error pulse stands only in the cycle right after the hand-over
    #1;
    if (req_error === 1'h1) err = 1'h1;
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1;
      if (req_error === 1'h1) err = 1'h1;
      if (cmd_valid === 1'h1) break;
    end
    check("cmd_valid", 16'(i < 8), 16'(ok));
    check("req_error", 16'(err), 16'(er));
    if (i < 8) begin
      check("cmd", 16'(cmd), 16'(c));
      if (c != ddrcd_pkg::cmd_refresh) check("cmd_bank", 16'(cmd_bank), 16'(b));
      if (c == ddrcd_pkg::cmd_open) check("row_addr", 16'(row_addr), 16'(a));
      if (c == ddrcd_pkg::cmd_read || c == ddrcd_pkg::cmd_write) begin
        check("col_addr", 16'(col_addr), 16'(a[9:0]));
        check("auto_close_flag", 16'(auto_close_flag), 16'(ac));
      end
    end
  endtask : do_cmd

  // bounded wait for a power state, then compare
  task automatic wait_pwr(input ddrcd_pkg::ddrcd_pwr_t p, input logic susp);
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      #1;
      if (pwr_state === p) break;
    end
    check("pwr_state", 16'(pwr_state), 16'(p));
    check("clk_suspended", 16'(clk_suspended), 16'(susp));
    check("link_cke", 16'(link_cke), 16'(!susp));
  endtask : wait_pwr

  // main sequence
  initial begin
    ref_clk = 1'h0;
    srst = 1'h1;
    req_valid = 1'h0;
    req_cmd = ddrcd_pkg::cmd_nop;
    req_bank = 2'h0;
    req_addr = 13'h0;
    req_auto_close = 1'h0;
    pd_req = 1'h0;
    sr_req = 1'h0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    #1;
    check("bank_active", 16'(bank_active), 16'h0);
    check("pwr_state", 16'(pwr_state), 16'(ddrcd_pkg::pwr_awake));
    $display("test reset done");
    // every bank opened, top row boundary first
    for (n = 0; n < 4; n++)
      do_cmd(ddrcd_pkg::cmd_open, 2'(n), 13'h1fff - 13'(n), 1'h0, 1'h1, 1'h0);
    check("bank_active", 16'(bank_active), 16'h000f);
    check("bank_open", 16'(bank_open), 16'h000f);
    $display("test open done");
    do_cmd(ddrcd_pkg::cmd_read, 2'h2, 13'h03ff, 1'h0, 1'h1, 1'h0);
    do_cmd(ddrcd_pkg::cmd_write, 2'h1, 13'h0155, 1'h1, 1'h1, 1'h0);
    check("bank_active", 16'(bank_active), 16'h000d);
    check("bank_open", 16'(bank_open), 16'h000d);
    do_cmd(ddrcd_pkg::cmd_close, 2'h0, 13'h0, 1'h0, 1'h1, 1'h0);
    check("bank_active", 16'(bank_active), 16'h000c);
    do_cmd(ddrcd_pkg::cmd_read, 2'h0, 13'h0, 1'h0, 1'h0, 1'h1);
    do_cmd(ddrcd_pkg::cmd_nop, 2'h3, 13'h0, 1'h0, 1'h0, 1'h0);
    do_cmd(ddrcd_pkg::cmd_other, 2'h3, 13'h0, 1'h0, 1'h0, 1'h0);
    $display("test column done");
    do_cmd(ddrcd_pkg::cmd_close, 2'h2, 13'h0, 1'h0, 1'h1, 1'h0);
    do_cmd(ddrcd_pkg::cmd_close, 2'h3, 13'h0, 1'h0, 1'h1, 1'h0);
    do_cmd(ddrcd_pkg::cmd_refresh, 2'h0, 13'h0, 1'h0, 1'h1, 1'h0);
    // one tick per crossing while awake
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      if (xfer_tick === 1'h1) n++;
    end
    check("xfer_tick count", 16'(n), 16'h0008);
    // power-down then self refresh, each left again
    @(posedge ref_clk);
    pd_req <= 1'h1;
    wait_pwr(ddrcd_pkg::pwr_down, 1'h1);
    @(posedge ref_clk);
    pd_req <= 1'h0;
    wait_pwr(ddrcd_pkg::pwr_awake, 1'h0);
    @(posedge ref_clk);
    sr_req <= 1'h1;
    wait_pwr(ddrcd_pkg::pwr_self, 1'h1);
    check("bank_active", 16'(bank_active), 16'h0);
    @(posedge ref_clk);
    sr_req <= 1'h0;
    wait_pwr(ddrcd_pkg::pwr_awake, 1'h0);
    $display("test power done");
    tally_and_finish();
  end
endmodule : tb_ddr_sdram_command_decode
`default_nettype wire
